// ---- src/port_io_map.svh ----
`ifndef PORT_IO_MAP_SVH
`define PORT_IO_MAP_SVH

// ----------------------------------------------------------------------
// widths and field positions
// ----------------------------------------------------------------------
`define PORT_WIDTH          8
`define FIXED_HALF          4
`define CFG_OUT_STYLE_BIT   1
`define CFG_CMP_OUT_BIT     0
`define TCTL_OUT_SEL_BIT    0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define BIDIR_DIR_RST       8'hFF
`define BIDIR_DATA_RST      8'h00
`define FIXED_DATA_RST      4'h0
`define CFG_RST             8'h00
`define TCTL_RST            8'h00

`endif

// ---- src/port_io_pkg.sv ----
package port_io_pkg;

	typedef logic [7:0] port_byte_t;
	typedef logic [3:0] port_nib_t;

endpackage

// ---- src/fixed_port_out.sv ----
`timescale 1ns/100ps
`include "port_io_map.svh"

// ----------------------------------------------------------------------
// fixed port upper lines: port data, with line 0 optionally the timer output, registered
// ----------------------------------------------------------------------
module fixed_port_out
	import port_io_pkg::*;
(
	input  wire logic      ref_clk_in,
	input  wire logic      rst_in,
	input  wire port_nib_t data_in,
	input  wire logic      timer_sel_in,
	input  wire logic      byte_timer_output_in,
	output port_nib_t      lines_out
);

	port_nib_t lines_q;
	port_nib_t lines_d;

	always_comb begin
		lines_d = data_in;
		if (timer_sel_in) begin
			lines_d[0] = byte_timer_output_in;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			lines_q <= `FIXED_DATA_RST;
		end else begin
			lines_q <= lines_d;
		end
	end

	// always driven: output-only push-pull, no enable exists
	assign lines_out = lines_q;

endmodule

// ---- src/port_io_ctrl.sv ----
`timescale 1ns/100ps
`include "port_io_map.svh"

// Contract
// - bidir port all inputs after power-on reset
// - one config bit selects output drive style
// - style bit one push-pull, zero open-drain
// - stop recovery returns bidir port to input
// - fixed lower four lines are inputs only
// - fixed upper four lines push-pull outputs only
// - fixed inputs feed interrupts, output line 0 carries the timer
// - timer control bit zero routes timer output
module port_io_ctrl
	import port_io_pkg::*;
(
	input  wire logic       ref_clk_in,
	input  wire logic       rst_in,
	input  wire logic       stop_recovery_in,
	input  wire logic       dir_wr_in,
	input  wire port_byte_t dir_in,
	input  wire logic       bidir_data_wr_in,
	input  wire port_byte_t bidir_data_in,
	input  wire logic       port_config_reg_wr_in,
	input  wire port_byte_t port_config_reg_in,
	input  wire logic       byte_timer_control_reg_wr_in,
	input  wire port_byte_t byte_timer_control_reg_in,
	input  wire logic       fixed_data_wr_in,
	input  wire port_nib_t  fixed_data_in,
	input  wire logic       byte_timer_output_in,
	input  wire port_byte_t bidir_port_lines_in,
	output port_byte_t      bidir_port_lines_out,
	output port_byte_t      bidir_port_lines_oe_out,
	output port_byte_t      bidir_rd_out,
	input  wire port_nib_t  fixed_port_lines_in,
	output port_nib_t       fixed_port_lines_out,
	output port_nib_t       fixed_rd_out,
	output port_nib_t       fixed_irq_src_out
);

	// ------------------------------------------------------------------
	// helper
	// ------------------------------------------------------------------
	// a line is driven when it is an output and, in open-drain style,
	// only while it pulls low
	function automatic port_byte_t drive_en(port_byte_t dir_inp,
		port_byte_t data, logic push_pull);
		port_byte_t en;
		en = ~dir_inp;
		if (!push_pull) begin
			en = en & ~data;
		end
		return en;
	endfunction

	// ------------------------------------------------------------------
	// bidirectional port, config, timer control and fixed port state
	// ------------------------------------------------------------------
	port_byte_t dir_q;
	port_byte_t bidir_data_q;
	port_byte_t cfg_q;
	port_byte_t tctl_q;
	port_nib_t  fixed_data_q;
	port_byte_t bidir_rd_q;
	port_nib_t  fixed_rd_q;

	// stop recovery beats a same-cycle direction write so pins never
	// glitch to output while the core is still waking
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			dir_q <= `BIDIR_DIR_RST;
		end else if (stop_recovery_in) begin
			dir_q <= `BIDIR_DIR_RST;
		end else if (dir_wr_in) begin
			dir_q <= dir_in;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			bidir_data_q <= `BIDIR_DATA_RST;
		end else if (bidir_data_wr_in) begin
			bidir_data_q <= bidir_data_in;
		end
	end

	// config and timer control survive stop recovery
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			cfg_q <= `CFG_RST;
		end else if (port_config_reg_wr_in) begin
			cfg_q <= port_config_reg_in;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			tctl_q <= `TCTL_RST;
		end else if (byte_timer_control_reg_wr_in) begin
			tctl_q <= byte_timer_control_reg_in;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			fixed_data_q <= `FIXED_DATA_RST;
		end else if (fixed_data_wr_in) begin
			fixed_data_q <= fixed_data_in;
		end
	end

	// ------------------------------------------------------------------
	// pin drive
	// ------------------------------------------------------------------
	// open-drain drives only zero, so the output value can stay the
	// data while the enable does the work
	assign bidir_port_lines_out    = bidir_data_q;
	assign bidir_port_lines_oe_out = drive_en(dir_q, bidir_data_q,
		cfg_q[`CFG_OUT_STYLE_BIT]);

	// ------------------------------------------------------------------
	// input sampling
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			bidir_rd_q <= `BIDIR_DATA_RST;
			fixed_rd_q <= `FIXED_DATA_RST;
		end else begin
			bidir_rd_q <= bidir_port_lines_in;
			fixed_rd_q <= fixed_port_lines_in;
		end
	end

	assign bidir_rd_out      = bidir_rd_q;
	assign fixed_rd_out      = fixed_rd_q;
	// interrupt logic elsewhere takes the sampled lower lines
	assign fixed_irq_src_out = fixed_rd_q;

	// ------------------------------------------------------------------
	// fixed outputs
	// ------------------------------------------------------------------
	fixed_port_out u_fixed_out (
		.ref_clk_in           (ref_clk_in),
		.rst_in               (rst_in),
		.data_in              (fixed_data_q),
		.timer_sel_in         (tctl_q[`TCTL_OUT_SEL_BIT]),
		.byte_timer_output_in (byte_timer_output_in),
		.lines_out            (fixed_port_lines_out)
	);

endmodule

// ---- verif/board_pins.sv ----
`timescale 1ns/100ps
module board_pins
	import port_io_pkg::*;
(
	input  wire port_byte_t oe_in,
	input  wire port_byte_t out_in,
	input  wire port_byte_t drv_en_in,
	input  wire port_byte_t drv_in,
	output port_byte_t      level_out
);
	// released lines float high on the pull-up; contention is not modelled
	assign level_out = (oe_in & out_in) | (~oe_in & (drv_in | ~drv_en_in));
endmodule

// ---- verif/port_io_properties.sv ----
`timescale 1ns/100ps
module port_io_properties
	import port_io_pkg::*;
(
	input wire logic       ref_clk_in,
	input wire logic       rst_in,
	input wire logic       stop_recovery_in,
	input wire logic       dir_wr_in,
	input wire port_byte_t dir_in,
	input wire logic       port_config_reg_wr_in,
	input wire port_byte_t port_config_reg_in,
	input wire logic       byte_timer_control_reg_wr_in,
	input wire port_byte_t byte_timer_control_reg_in,
	input wire logic       byte_timer_output_in,
	input wire port_byte_t bidir_port_lines_out,
	input wire port_byte_t bidir_port_lines_oe_out,
	input wire port_nib_t  fixed_port_lines_in,
	input wire port_nib_t  fixed_port_lines_out,
	input wire port_nib_t  fixed_rd_out,
	input wire port_nib_t  fixed_irq_src_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	// open-drain style as last written; reset leaves the port open-drain
	logic od_q;
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			od_q <= 1'b1;
		end else if (port_config_reg_wr_in) begin
			od_q <= !port_config_reg_in[1];
		end
	end
	sequence pp_out_s;
		port_config_reg_wr_in && port_config_reg_in[1] ##1 dir_wr_in &&
		dir_in == 8'h00 && !stop_recovery_in && !port_config_reg_wr_in;
	endsequence
	a_dir_reset: assert property (
		$fell(rst_in) |-> bidir_port_lines_oe_out == 8'h00) else $error("dir");
	a_data_reset: assert property (
		$fell(rst_in) |-> bidir_port_lines_out == 8'h00) else $error("data");
	a_stop_input: assert property (
		stop_recovery_in |=> bidir_port_lines_oe_out == 8'h00) else $error("stop");
	a_push_pull: assert property (
		pp_out_s |=> bidir_port_lines_oe_out == 8'hFF) else $error("pp");
	a_open_drain: assert property (
		od_q |-> (bidir_port_lines_oe_out & bidir_port_lines_out) == 8'h00)
		else $error("od");
	a_timer_route: assert property (
		byte_timer_control_reg_wr_in && byte_timer_control_reg_in[0] |-> ##2
		fixed_port_lines_out[0] == $past(byte_timer_output_in)) else $error("tm");
	a_fixed_rd: assert property (
		!$past(rst_in) |-> fixed_rd_out == $past(fixed_port_lines_in))
		else $error("rd");
	a_irq_src: assert property (
		!$past(rst_in) |-> fixed_irq_src_out == $past(fixed_port_lines_in))
		else $error("irq");
endmodule
bind port_io_ctrl port_io_properties u_props (.*);

// ---- verif/testbench.sv ----
`timescale 1ns/100ps
module testbench;
	import port_io_pkg::*;
	logic       ref_clk_in, rst_in, stop_recovery_in, dir_wr_in;
	logic       bidir_data_wr_in, port_config_reg_wr_in, fixed_data_wr_in;
	logic       byte_timer_control_reg_wr_in, byte_timer_output_in;
	port_byte_t dir_in, bidir_data_in, port_config_reg_in, bidir_rd_out;
	port_byte_t byte_timer_control_reg_in, bidir_port_lines_in, drv_en, drv;
	port_byte_t bidir_port_lines_out, bidir_port_lines_oe_out;
	port_nib_t  fixed_data_in, fixed_port_lines_in, fixed_port_lines_out;
	port_nib_t  fixed_rd_out, fixed_irq_src_out;
	int         num_errors, n_compared, cycles;
	port_io_ctrl u_port_io_ctrl (.*);
	board_pins u_board_pins (.oe_in(bidir_port_lines_oe_out),
		.out_in(bidir_port_lines_out), .drv_en_in(drv_en), .drv_in(drv),
		.level_out(bidir_port_lines_in));
	initial begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end
	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles == 2000) begin
			num_errors++;
			end_of_test();
		end
	end
	// each task lowers its own strobes, so none is written twice a step
	task tick(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask
	task check(input port_byte_t seen, input port_byte_t exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task end_of_test();
		$display("errors=%0d compared=%0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task drive_styles();
		{port_config_reg_wr_in, port_config_reg_in} = {1'b1, 8'h02};
		tick(1);
		port_config_reg_wr_in = 1'b0;
		{dir_wr_in, dir_in, bidir_data_wr_in, bidir_data_in} = 18'h201A5;
		tick(1);
		{dir_wr_in, bidir_data_wr_in} = 2'h0;
		check(bidir_port_lines_oe_out, 8'hFF);
		{port_config_reg_wr_in, port_config_reg_in} = {1'b1, 8'h00};
		tick(1);
		port_config_reg_wr_in = 1'b0;
		check(bidir_rd_out, 8'hA5);
		check(bidir_port_lines_oe_out, 8'h5A);
		check(bidir_port_lines_out, 8'hA5);
	endtask
	task stop_wins();
		{stop_recovery_in, dir_wr_in, dir_in} = {1'b1, 1'b1, 8'h00};
		tick(1);
		{stop_recovery_in, dir_wr_in} = 2'h0;
		check(bidir_port_lines_oe_out, 8'h00);
	endtask
	task pins_in();
		{dir_wr_in, dir_in, drv_en, drv} = {1'b1, 8'hFF, 8'hFF, 8'h3C};
		tick(1);
		dir_wr_in = 1'b0;
		tick(1);
		check(bidir_rd_out, 8'h3C);
		check(bidir_port_lines_oe_out, 8'h00);
	endtask
	task fixed_lines();
		{fixed_data_wr_in, fixed_data_in, fixed_port_lines_in} = 9'h1B6;
		tick(1);
		fixed_data_wr_in = 1'b0;
		tick(1);
		check({4'h0, fixed_port_lines_out}, 8'h0B);
		check({fixed_rd_out, fixed_irq_src_out}, 8'h66);
		{byte_timer_control_reg_wr_in, byte_timer_control_reg_in} = 9'h101;
		tick(1);
		byte_timer_control_reg_wr_in = 1'b0;
		tick(1);
		check({4'h0, fixed_port_lines_out}, 8'h0A);
		byte_timer_output_in = 1'b1;
		tick(2);
		check({4'h0, fixed_port_lines_out}, 8'h0B);
	endtask
	task reset_mid();
		rst_in = 1'b1;
		tick(2);
		rst_in = 1'b0;
		check(bidir_port_lines_oe_out, 8'h00);
		check(bidir_port_lines_out, 8'h00);
		check({4'h0, fixed_port_lines_out}, 8'h00);
		tick(2);
		check({4'h0, fixed_port_lines_out}, 8'h00);
	endtask
	initial begin
		{rst_in, stop_recovery_in, dir_wr_in, bidir_data_wr_in} = 4'h8;
		{port_config_reg_wr_in, byte_timer_control_reg_wr_in} = 2'h0;
		{fixed_data_wr_in, byte_timer_output_in, drv_en, drv} = 18'h0;
		{dir_in, bidir_data_in, port_config_reg_in} = 24'h0;
		{byte_timer_control_reg_in, fixed_data_in, fixed_port_lines_in} = 16'h0;
		tick(16);
		rst_in = 1'b0;
		check(bidir_port_lines_oe_out, 8'h00);
		drive_styles();
		stop_wins();
		pins_in();
		fixed_lines();
		reset_mid();
		end_of_test();
	end
endmodule
